// ---- hbiu_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module hbiu_host_model (
    output logic             host_bus_clock,
    output logic             host_cs_n,
    output logic             host_rd_n,
    output logic             host_wr_n,
    output logic [15:0]      host_addr,
    output logic [31:0]      host_data_in,
    input  wire logic        host_wait_ready,
    input  wire logic        host_wait_ready_oe,
    input  wire logic [31:0] host_data_out
);
    initial begin
        {host_bus_clock, host_addr, host_data_in} = '0;
        {host_cs_n, host_rd_n, host_wr_n} = 3'h7;
    end
    // 64 ns host clock, slower than the core clock
    task automatic tick();
        #32 host_bus_clock = 1;
        #32 host_bus_clock = 0;
    endtask : tick
    // Clock runs only inside an access
    task automatic access(input logic we, input logic [15:0] a,
        input logic [31:0] d, input int lim,
        output logic [31:0] q, output logic ok);
        int n;
        #1 n = 0;
        ok = 0;
        host_addr = a;
        host_data_in = we ? d : ~host_data_in;
        {host_cs_n, host_rd_n, host_wr_n} = {1'b0, we, !we};
        while (n < lim && !ok) begin
            tick();
            n++;
            ok = host_wait_ready_oe && host_wait_ready;
        end
        q = host_data_out;
        {host_cs_n, host_rd_n, host_wr_n} = 3'h7;
        host_data_in = ~host_data_in;
        repeat (3) tick();
    endtask : access
endmodule : hbiu_host_model
`default_nettype wire

// ---- hbiu_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module hbiu_monitor (
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        in_fifo_wr,
    input wire logic        out_fifo_rd,
    input wire logic        host_data_oe,
    input wire logic        host_wait_ready_oe,
    input wire logic        reg_req,
    input wire logic [11:0] reg_addr,
    input wire logic        reg_ack,
    input wire logic        mem_req,
    input wire logic [11:0] mem_addr,
    input wire logic        mem_ack
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_setup; psel && !penable; endsequence
    sequence s_reg_wait; reg_req && !reg_ack; endsequence
    sequence s_mem_wait; mem_req && !mem_ack; endsequence
    a_pready_after_setup: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    a_pready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_slverr_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_fifo_wr_single: assert property (in_fifo_wr |=> !in_fifo_wr)
        else $error("input fifo write not a pulse");
    a_out_rd_single: assert property (out_fifo_rd |=> !out_fifo_rd)
        else $error("output fifo read not a pulse");
    a_reg_req_held: assert property (s_reg_wait |=>
        reg_req && $stable(reg_addr))
        else $error("register request dropped before ack");
    a_mem_req_held: assert property (s_mem_wait |=>
        mem_req && $stable(mem_addr))
        else $error("memory request dropped before ack");
    a_data_oe_selected: assert property (host_data_oe |->
        host_wait_ready_oe)
        else $error("data driven while not selected");
endmodule : hbiu_monitor
bind hbiu_top hbiu_monitor u_mon (.mclk, .reset_n, .psel, .penable,
    .pready, .pslverr, .in_fifo_wr, .out_fifo_rd, .host_data_oe,
    .host_wait_ready_oe, .reg_req, .reg_addr, .reg_ack, .mem_req,
    .mem_addr, .mem_ack);
`default_nettype wire

// ---- hbiu_pkg.sv ----
`default_nettype none
package hbiu_pkg;
    // Host address, counted in halfwords
    localparam int HBIU_DEV_LSB    = 14;
    localparam int HBIU_SDRAM_BIT  = 13;
    localparam logic [11:0] HBIU_HW_IN_FIFO  = 12'h000;
    localparam logic [11:0] HBIU_HW_OUT_FIFO = 12'h001;
    localparam logic [11:0] HBIU_HW_CMD      = 12'h002;

    // Strap positions on the mode pins
    localparam int HBIU_STRAP_WIDE16  = 2;
    localparam int HBIU_STRAP_RDY_INV = 3;
    localparam logic [1:0] HBIU_STRAP_SETTLE = 2'h3;

    // APB byte offsets
    localparam logic [7:0] HBIU_OFS_CTRL   = 8'h00;
    localparam logic [7:0] HBIU_OFS_LIMIT  = 8'h04;
    localparam logic [7:0] HBIU_OFS_THRESH = 8'h08;
    localparam logic [7:0] HBIU_OFS_STATUS = 8'h0C;
    localparam logic [7:0] HBIU_OFS_CLEAR  = 8'h10;
    localparam logic [7:0] HBIU_OFS_ENABLE = 8'h14;
    localparam logic [7:0] HBIU_OFS_LEVEL  = 8'h18;
    localparam logic [7:0] HBIU_OFS_BEHAVE = 8'h1C;
    localparam logic [7:0] HBIU_OFS_STATE  = 8'h20;

    // Control register fields
    localparam int HBIU_CTRL_DMA_EN = 0;
    localparam int HBIU_CTRL_DMA_RD = 1;
    localparam int HBIU_CTRL_DEMAND = 2;
    localparam int HBIU_THR_OUT_LSB = 16;

    // Flag positions
    localparam int HBIU_NFLAG       = 5;
    localparam int HBIU_F_IN_SPACE  = 0;
    localparam int HBIU_F_OUT_DATA  = 1;
    localparam int HBIU_F_CMD_FREE  = 2;
    localparam int HBIU_F_CMD_DONE  = 3;
    localparam int HBIU_F_DMA_BLOCK = 4;

    // Values after reset
    localparam logic [2:0] HBIU_RST_CTRL   = 3'h0;
    localparam logic [4:0] HBIU_RST_ENABLE = 5'h00;
    localparam logic [4:0] HBIU_RST_LEVEL  = 5'h1F;
    localparam logic [4:0] HBIU_RST_BEHAVE = 5'h00;
    localparam logic [7:0] HBIU_RST_LIMIT  = 8'h10;
    localparam logic [7:0] HBIU_RST_THR    = 8'h01;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_EXEC = 2'b01,
        H_WAIT = 2'b10,
        H_DONE = 2'b11
    } hbiu_state_t;
endpackage : hbiu_pkg
`default_nettype wire

// ---- hbiu_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
    import hbiu_pkg::*;
    logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic cmd_done = 0, reg_ack = 0, mem_ack = 0, ok, err;
    logic [7:0] paddr = '0, in_fifo_free = 8'h20, out_fifo_count = '0;
    logic [31:0] pwdata = '0, out_fifo_rdata = '0, reg_rdata = '0;
    logic [31:0] mem_rdata = '0, prdata, host_data_out, in_fifo_wdata;
    logic [31:0] cmd_word, reg_wdata, mem_wdata, host_data_in, got, fifo_last;
    logic [15:0] host_addr, lfsr_q = 16'h0022;
    logic [11:0] reg_addr, mem_addr;
    logic [3:0] mode_pins = 4'h1;
    logic [1:0] stall_q = '0;
    logic pready, pslverr, irq, host_bus_clock, host_cs_n, host_rd_n;
    logic host_wr_n, host_data_oe, host_wait_ready, host_wait_ready_oe;
    logic host_dma_req, in_fifo_wr, out_fifo_rd, cmd_valid, reg_req;
    logic reg_we, mem_req, mem_we;
    logic [7:0] ofs [5] = '{HBIU_OFS_CTRL, HBIU_OFS_LIMIT, HBIU_OFS_ENABLE,
        HBIU_OFS_LEVEL, HBIU_OFS_BEHAVE};
    logic [31:0] rv [5] = '{32'(HBIU_RST_CTRL), 32'(HBIU_RST_LIMIT),
        32'(HBIU_RST_ENABLE), 32'(HBIU_RST_LEVEL), 32'(HBIU_RST_BEHAVE)};
    int error_cnt = 0, comparisons = 0;
    hbiu_top #(.FIFO_CW(8)) DUT (.mclk, .reset_n, .clk_en(1'b1), .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
        .host_bus_clock, .host_cs_n, .host_rd_n, .host_wr_n, .host_addr,
        .host_data_in, .host_data_out, .host_data_oe, .host_wait_ready,
        .host_wait_ready_oe, .host_dma_req, .mode_pins, .in_fifo_wr,
        .in_fifo_wdata, .in_fifo_free, .out_fifo_rd, .out_fifo_rdata,
        .out_fifo_count, .cmd_valid, .cmd_word, .cmd_done, .reg_req, .reg_we,
        .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .mem_req, .mem_we,
        .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
    hbiu_host_model host (.host_bus_clock, .host_cs_n, .host_rd_n,
        .host_wr_n, .host_addr, .host_data_in, .host_wait_ready,
        .host_wait_ready_oe, .host_data_out);
    always #2 mclk = ~mclk;
    // Varying stall, like a busy arbiter
    always @(posedge mclk) begin
        stall_q <= stall_q + 2'h1;
        reg_ack <= reg_req && !reg_ack;
        mem_ack <= mem_req && !mem_ack && stall_q == 2'h0;
        if (in_fifo_wr) fifo_last <= in_fifo_wdata;
    end
    function automatic logic [31:0] rnd();
        repeat (32) lfsr_q = {lfsr_q[14:0],
            lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return {lfsr_q, ~lfsr_q[7:0], lfsr_q[15:8]};
    endfunction : rnd
    function automatic logic [15:0] ha(input logic [1:0] dv,
        input logic sd, input logic [11:0] w, input logic h);
        return {dv, sd, w, h};
    endfunction : ha
    task automatic check(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk) penable <= 1;
        do @(posedge mclk); while (pready !== 1'b1);
        got = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        repeat (2) @(posedge mclk);
    endtask : apb
    task automatic close_out();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    initial begin
        #200000 error_cnt++;
        close_out();
    end
    initial begin
        logic [31:0] d, c;
        repeat (16) @(posedge mclk);
        reset_n <= 1;
        foreach (ofs[i]) begin
            apb(0, ofs[i], '0);
            check("reset value", got, rv[i]);
        end
        apb(0, 8'h40, '0);
        check("unmapped error", err, 1);
        check("unmapped data", got, '0);
        apb(0, HBIU_OFS_STATUS, '0);
        check("status", got, 5 << HBIU_F_IN_SPACE);
        out_fifo_count <= 8'h03;
        repeat (4) @(posedge mclk);
        out_fifo_count <= 8'h00;
        apb(1, HBIU_OFS_ENABLE, 1 << HBIU_F_OUT_DATA);
        check("irq enabled", irq, 1);
        apb(1, HBIU_OFS_ENABLE, '0);
        check("irq masked", irq, 0);
        apb(1, HBIU_OFS_ENABLE, 1 << HBIU_F_OUT_DATA);
        apb(1, HBIU_OFS_CLEAR, 1 << HBIU_F_OUT_DATA);
        apb(0, HBIU_OFS_STATUS, '0);
        check("irq cleared", irq, 0);
        apb(1, HBIU_OFS_CTRL, 1);
        check("dma req", host_dma_req, 1);
        d = rnd();
        host.access(1, ha(1, 0, '0, 0), d, 60, got, ok);
        check("fifo write", fifo_last, d);
        host.access(1, ha(2, 0, '0, 0), ~d, 20, got, ok);
        check("foreign ready", ok, 0);
        check("foreign fifo", fifo_last, d);
        reg_rdata = rnd();
        host.access(0, ha(1, 0, 12'h005, 0), '0, 60, got, ok);
        check("reg read", got, reg_rdata);
        check("reg addr", reg_addr, 12'h005);
        c = rnd();
        host.access(1, ha(1, 0, HBIU_HW_CMD, 0), c, 60, got, ok);
        host.access(1, ha(1, 0, HBIU_HW_CMD, 0), ~c, 60, got, ok);
        host.access(0, ha(1, 0, HBIU_HW_CMD, 0), '0, 60, got, ok);
        check("cmd pipe", got, 32'h0000_0003);
        check("cmd running", cmd_word, c);
        mem_rdata = rnd();
        host.access(0, ha(1, 1, 12'h007, 0), '0, 80, got, ok);
        check("sdram read", got, mem_rdata);
        check("sdram addr", mem_addr, 12'h007);
        @(posedge mclk) cmd_done <= 1;
        @(posedge mclk) cmd_done <= 0;
        repeat (2) @(posedge mclk);
        check("cmd next", cmd_word, ~c);
        reset_n <= 0;
        mode_pins <= 4'h5;
        repeat (16) @(posedge mclk);
        reset_n <= 1;
        repeat (4) @(posedge mclk);
        d = rnd();
        host.access(1, ha(1, 0, '0, 0), {16'h0000, d[15:0]}, 60, got, ok);
        host.access(1, ha(1, 0, '0, 1), {16'h0000, d[31:16]}, 60, got, ok);
        check("wide word", fifo_last, d);
        out_fifo_rdata = ~d;
        out_fifo_count = 8'h04;
        host.access(0, ha(1, 0, HBIU_HW_OUT_FIFO, 0), '0, 60, got, ok);
        check("low half", got, {16'h0000, ~d[15:0]});
        host.access(0, ha(1, 0, HBIU_HW_OUT_FIFO, 1), '0, 60, got, ok);
        check("high half", got, {16'h0000, ~d[31:16]});
        close_out();
    end
endmodule : tb
`default_nettype wire

// ---- hbiu_top.sv ----
// Behaviour
// (R1) Host addresses decode to own regs, registers, SDRAM, FIFOs.
// (R2) Reads mux the target's data; ready waits until data exists.
// (R3) Device data passes one input, one output FIFO at fixed words.
// (R4) Only host sides are driven: input writes, output reads.
// (R5) Two-stage command pipeline: one pending, one running.
// (R6) SDRAM mapped directly; arbitration delay extends the wait.
// (R7) Register and SDRAM accesses run beside commands.
// (R8) DMA flow control on the same bus, one direction at a time.
// (R9) FIFO flags rise at programmed thresholds.
// (R10) Each flag reaches the interrupt through its enable bit.
// (R11) Each flag is level or edge signalled.
// (R12) Each flag is dynamic (hardware clears) or static.
// (R13) DMA uses programmed limits; demand mode computes the count.
// (R14) Outside demand mode the host guarantees input FIFO space.
// (R15) Host clock is no faster than the core clock.
// (R16) 16-bit strap: writes joined to 32 bits, reads split.
// (R17) Two strap bits give the device number; own range only.
// (R18) A strap inverts ready; pins drive only when selected.
// (R19) Lower halfword is the low half; write after both halves.
`timescale 1ns/100ps
`default_nettype none
module hbiu_top
    import hbiu_pkg::*;
#(
    parameter int FIFO_CW = 8
) (
    input  wire logic               mclk,
    input  wire logic               reset_n,
    input  wire logic               clk_en,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic                    irq,
    input  wire logic               host_bus_clock,
    input  wire logic               host_cs_n,
    input  wire logic               host_rd_n,
    input  wire logic               host_wr_n,
    input  wire logic [15:0]        host_addr,
    input  wire logic [31:0]        host_data_in,
    output logic      [31:0]        host_data_out,
    output logic                    host_data_oe,
    output logic                    host_wait_ready,
    output logic                    host_wait_ready_oe,
    output logic                    host_dma_req,
    input  wire logic [3:0]         mode_pins,
    output logic                    in_fifo_wr,
    output logic      [31:0]        in_fifo_wdata,
    input  wire logic [FIFO_CW-1:0] in_fifo_free,
    output logic                    out_fifo_rd,
    input  wire logic [31:0]        out_fifo_rdata,
    input  wire logic [FIFO_CW-1:0] out_fifo_count,
    output logic                    cmd_valid,
    output logic      [31:0]        cmd_word,
    input  wire logic               cmd_done,
    output logic                    reg_req,
    output logic                    reg_we,
    output logic      [11:0]        reg_addr,
    output logic      [31:0]        reg_wdata,
    input  wire logic [31:0]        reg_rdata,
    input  wire logic               reg_ack,
    output logic                    mem_req,
    output logic                    mem_we,
    output logic      [11:0]        mem_addr,
    output logic      [31:0]        mem_wdata,
    input  wire logic [31:0]        mem_rdata,
    input  wire logic               mem_ack
);
    localparam int NF = HBIU_NFLAG;

    // Pin synchronisers: {clock, cs, rd, wr}
    logic [3:0]          hc_s1_q, hc_s2_q;
    logic                hclk_prev_q;
    logic [15:0]         ha_s1_q, ha_s2_q;
    logic [31:0]         hd_s1_q, hd_s2_q;
    logic [3:0]          st_s1_q, st_s2_q, strap_q;
    logic [1:0]          strap_cnt_q;

    hbiu_state_t         state_q, state_d;
    logic [15:0]         acc_addr_q;
    logic [31:0]         acc_wdata_q;
    logic                acc_rd_q;
    logic [15:0]         half_q;
    logic                pend_q;
    logic [31:0]         pend_word_q;

    logic [2:0]          ctrl_q;
    logic [FIFO_CW-1:0]  limit_q, in_thr_q, out_thr_q, blk_cnt_q;
    logic [NF-1:0]       flag_q, flag_d, enable_q, level_q, behave_q;
    logic [NF-1:0]       cond_prev_q;

    // Only the second stage is read (R15)
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            hc_s1_q     <= 4'hF;
            hc_s2_q     <= 4'hF;
            hclk_prev_q <= 1'b1;
            ha_s1_q     <= 16'h0000;
            ha_s2_q     <= 16'h0000;
            hd_s1_q     <= 32'h0000_0000;
            hd_s2_q     <= 32'h0000_0000;
            st_s1_q     <= 4'h0;
            st_s2_q     <= 4'h0;
        end else if (clk_en) begin
            hc_s1_q     <= {host_bus_clock, host_cs_n, host_rd_n, host_wr_n};
            hc_s2_q     <= hc_s1_q;
            hclk_prev_q <= hc_s2_q[3];
            ha_s1_q     <= host_addr;
            ha_s2_q     <= ha_s1_q;
            hd_s1_q     <= host_data_in;
            hd_s2_q     <= hd_s1_q;
            st_s1_q     <= mode_pins;
            st_s2_q     <= st_s1_q;
        end
    end

    // Straps caught in the first three cycles after reset, then held
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            strap_cnt_q <= 2'h0;
            strap_q     <= 4'h0;
        end else if (clk_en && strap_cnt_q != HBIU_STRAP_SETTLE) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            strap_q     <= st_s2_q;
        end
    end

    wire straps_ok = (strap_cnt_q == HBIU_STRAP_SETTLE);
    wire wide16    = strap_q[HBIU_STRAP_WIDE16];
    wire rdy_inv   = strap_q[HBIU_STRAP_RDY_INV];
    wire hclk_rise = hc_s2_q[3] & ~hclk_prev_q;
    wire h_cs      = ~hc_s2_q[2];
    wire h_rd      = ~hc_s2_q[1];
    wire h_wr      = ~hc_s2_q[0];
    wire h_strobe  = h_cs & (h_rd | h_wr);
    wire dev_hit   = (ha_s2_q[15:HBIU_DEV_LSB] == strap_q[1:0]); // R17
    wire h_start   = (state_q == H_IDLE) & straps_ok & hclk_rise
                   & h_strobe & dev_hit;

    wire [11:0] acc_word = acc_addr_q[12:1];
    wire half_hi  = wide16 & acc_addr_q[0];
    wire half_lo  = wide16 & ~acc_addr_q[0];
    wire tgt_mem  = acc_addr_q[HBIU_SDRAM_BIT]; // R6
    wire tgt_in   = ~tgt_mem & (acc_word == HBIU_HW_IN_FIFO); // R3
    wire tgt_out  = ~tgt_mem & (acc_word == HBIU_HW_OUT_FIFO); // R3
    wire tgt_cmd  = ~tgt_mem & (acc_word == HBIU_HW_CMD);
    wire tgt_reg  = ~tgt_mem & ~tgt_in & ~tgt_out & ~tgt_cmd; // R1
    // A lone lower write half or an upper read half needs no target
    wire skip     = acc_rd_q ? half_hi : half_lo; // R19
    wire in_ok    = (in_fifo_free != '0);
    wire out_ok   = (out_fifo_count != '0);
    wire fifo_bad = (tgt_in & acc_rd_q) | (tgt_out & ~acc_rd_q);
    wire quick    = skip | fifo_bad | (tgt_in & in_ok)
                  | (tgt_out & out_ok) | (tgt_cmd & (acc_rd_q | ~pend_q));
    wire slow     = ~skip & (tgt_mem | tgt_reg);
    wire in_exec  = (state_q == H_EXEC);
    wire act      = in_exec & quick & ~skip & ~fifo_bad;
    wire in_wr_d  = act & tgt_in; // R4
    wire out_rd_d = act & tgt_out; // R4
    wire cmd_load = act & tgt_cmd & ~acc_rd_q; // R5
    wire slow_ack = tgt_mem ? mem_ack : reg_ack;
    wire finish   = (in_exec & quick) | ((state_q == H_WAIT) & slow_ack);

    wire [31:0] wr_word = wide16 ? {acc_wdata_q[15:0], half_q} // R16
                                 : acc_wdata_q;
    wire [31:0] cmd_stat = {30'h0000_0000, pend_q, cmd_valid};
    wire [31:0] quick_word = tgt_out ? out_fifo_rdata
                           : tgt_cmd ? cmd_stat : 32'h0000_0000;
    wire [31:0] src_word = (state_q == H_WAIT) // R2
                         ? (tgt_mem ? mem_rdata : reg_rdata) : quick_word;
    wire [31:0] out_word = !wide16 ? src_word // R16
                         : {16'h0000, half_hi ? half_q : src_word[15:0]};

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            H_IDLE: if (h_start) state_d = H_EXEC;
            H_EXEC: begin
                if (quick) state_d = H_DONE;
                else if (slow) state_d = H_WAIT;
            end
            H_WAIT: if (slow_ack) state_d = H_DONE; // R6
            H_DONE: if (!h_strobe) state_d = H_IDLE;
        endcase
    end

    // Access capture; a read wins when both strobes are seen
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_q     <= H_IDLE;
            acc_addr_q  <= 16'h0000;
            acc_wdata_q <= 32'h0000_0000;
            acc_rd_q    <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            if (h_start) begin
                acc_addr_q  <= ha_s2_q;
                acc_wdata_q <= hd_s2_q;
                acc_rd_q    <= h_rd;
            end
        end
    end

    // Ready holds wait until the answer stands
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            host_data_out      <= 32'h0000_0000;
            host_data_oe       <= 1'b0;
            host_wait_ready    <= 1'b0;
            host_wait_ready_oe <= 1'b0;
            half_q             <= 16'h0000;
        end else if (clk_en) begin
            host_wait_ready    <= (state_d == H_DONE) ^ rdy_inv;        // R2 R18
            host_wait_ready_oe <= straps_ok & h_cs & dev_hit;           // R18
            host_data_oe       <= (state_d == H_DONE) & acc_rd_q
                                  & h_cs & dev_hit; // R18
            if (finish && acc_rd_q) begin
                host_data_out <= out_word; // R2
            end
            if (finish && half_lo) begin
                half_q <= acc_rd_q ? src_word[31:16] : acc_wdata_q[15:0]; // R19
            end
        end
    end

    // Register and SDRAM run beside commands (R7)
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            in_fifo_wr    <= 1'b0;
            in_fifo_wdata <= 32'h0000_0000;
            out_fifo_rd   <= 1'b0;
            reg_req       <= 1'b0;
            reg_we        <= 1'b0;
            reg_addr      <= 12'h000;
            reg_wdata     <= 32'h0000_0000;
            mem_req       <= 1'b0;
            mem_we        <= 1'b0;
            mem_addr      <= 12'h000;
            mem_wdata     <= 32'h0000_0000;
        end else if (clk_en) begin
            in_fifo_wr  <= in_wr_d;
            out_fifo_rd <= out_rd_d;
            if (in_wr_d) in_fifo_wdata <= wr_word;
            if (in_exec && slow && tgt_reg) begin // R1
                reg_req   <= 1'b1;
                reg_we    <= ~acc_rd_q;
                reg_addr  <= acc_word;
                reg_wdata <= wr_word;
            end else if (reg_ack) begin
                reg_req <= 1'b0;
            end
            if (in_exec && slow && tgt_mem) begin // R6
                mem_req   <= 1'b1;
                mem_we    <= ~acc_rd_q;
                mem_addr  <= acc_word;
                mem_wdata <= wr_word;
            end else if (mem_ack) begin
                mem_req <= 1'b0;
            end
        end
    end

    wire promote = pend_q & (~cmd_valid | cmd_done); // R5
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pend_q      <= 1'b0;
            pend_word_q <= 32'h0000_0000;
            cmd_valid   <= 1'b0;
            cmd_word    <= 32'h0000_0000;
        end else if (clk_en) begin
            if (cmd_load) begin
                pend_q      <= 1'b1;
                pend_word_q <= wr_word;
            end else if (promote) begin
                pend_q <= 1'b0;
            end
            if (promote) begin
                cmd_valid <= 1'b1;
                cmd_word  <= pend_word_q;
            end else if (cmd_done) begin
                cmd_valid <= 1'b0;
            end
        end
    end

    // One direction bit: one way at a time (R8)
    wire dma_en    = ctrl_q[HBIU_CTRL_DMA_EN];
    wire dma_to_in = ~ctrl_q[HBIU_CTRL_DMA_RD];
    wire demand    = ctrl_q[HBIU_CTRL_DEMAND];
    wire [FIFO_CW-1:0] dma_avail = dma_to_in ? in_fifo_free : out_fifo_count;
    wire [FIFO_CW-1:0] dma_amount = !demand ? limit_q
                     : (dma_avail < limit_q ? dma_avail : limit_q); // R13
    wire dma_arm   = dma_en & (blk_cnt_q == '0) & (dma_amount != '0);
    wire dma_xfer  = (blk_cnt_q != '0)
                   & (dma_to_in ? in_fifo_wr : out_fifo_rd);
    wire dma_blk_done = dma_xfer & (blk_cnt_q == FIFO_CW'(1));

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            blk_cnt_q    <= '0;
            host_dma_req <= 1'b0;
        end else if (clk_en) begin
            if (!dma_en) begin
                blk_cnt_q <= '0;
            end else if (dma_arm) begin
                blk_cnt_q <= dma_amount; // R13
            end else if (dma_xfer) begin
                blk_cnt_q <= blk_cnt_q - FIFO_CW'(1);
            end
            host_dma_req <= dma_en & ((blk_cnt_q != '0) | dma_arm)
                            & ~dma_blk_done; // R8
        end
    end

    logic [NF-1:0] cond, set_ev, hw_clr, sw_clr;
    assign cond[HBIU_F_IN_SPACE]  = (in_fifo_free >= in_thr_q); // R9
    assign cond[HBIU_F_OUT_DATA]  = (out_fifo_count >= out_thr_q); // R9
    assign cond[HBIU_F_CMD_FREE]  = ~pend_q;
    assign cond[HBIU_F_CMD_DONE]  = cmd_done & cmd_valid;
    assign cond[HBIU_F_DMA_BLOCK] = dma_blk_done;
    assign set_ev = (level_q & cond) | (~level_q & cond & ~cond_prev_q); // R11
    assign hw_clr = behave_q & ~cond; // R12
    // A new event beats a clear in the same cycle
    assign flag_d = set_ev | (flag_q & ~sw_clr & ~hw_clr); // R12

    // APB: one access cycle, no wait states
    wire apb_setup = psel & ~penable;
    wire apb_wr    = psel & penable & pready & pwrite & ~pslverr;
    wire a_ctrl    = (paddr == HBIU_OFS_CTRL);
    wire a_limit   = (paddr == HBIU_OFS_LIMIT);
    wire a_thresh  = (paddr == HBIU_OFS_THRESH);
    wire a_status  = (paddr == HBIU_OFS_STATUS);
    wire a_clear   = (paddr == HBIU_OFS_CLEAR);
    wire a_enable  = (paddr == HBIU_OFS_ENABLE);
    wire a_level   = (paddr == HBIU_OFS_LEVEL);
    wire a_behave  = (paddr == HBIU_OFS_BEHAVE);
    wire a_state   = (paddr == HBIU_OFS_STATE);
    wire a_ok      = a_ctrl | a_limit | a_thresh | a_status | a_clear
                   | a_enable | a_level | a_behave | a_state;
    assign sw_clr = (apb_wr && a_clear) ? pwdata[NF-1:0] : '0;
    wire [31:0] thr_word = 32'(out_thr_q) << HBIU_THR_OUT_LSB | 32'(in_thr_q);
    wire [31:0] state_word = 32'({blk_cnt_q, 7'h00, cmd_valid, pend_q,
                                  state_q, 1'b0, strap_q});
    wire [31:0] apb_rdata = a_ctrl   ? 32'(ctrl_q)
                          : a_limit  ? 32'(limit_q)
                          : a_thresh ? thr_word
                          : a_status ? 32'(flag_q)
                          : a_enable ? 32'(enable_q)
                          : a_level  ? 32'(level_q)
                          : a_behave ? 32'(behave_q)
                          : a_state  ? state_word : 32'h0000_0000;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~a_ok;
            if (apb_setup) prdata <= apb_rdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ctrl_q      <= HBIU_RST_CTRL;
            limit_q     <= FIFO_CW'(HBIU_RST_LIMIT);
            in_thr_q    <= FIFO_CW'(HBIU_RST_THR);
            out_thr_q   <= FIFO_CW'(HBIU_RST_THR);
            enable_q    <= HBIU_RST_ENABLE;
            level_q     <= HBIU_RST_LEVEL;
            behave_q    <= HBIU_RST_BEHAVE;
            flag_q      <= '0;
            cond_prev_q <= '0;
            irq         <= 1'b0;
        end else if (clk_en) begin
            if (apb_wr && a_ctrl)   ctrl_q   <= pwdata[2:0];
            if (apb_wr && a_limit)  limit_q  <= pwdata[FIFO_CW-1:0]; // R13
            if (apb_wr && a_thresh) begin
                in_thr_q  <= pwdata[FIFO_CW-1:0]; // R9
                out_thr_q <= pwdata[HBIU_THR_OUT_LSB +: FIFO_CW]; // R9
            end
            if (apb_wr && a_enable) enable_q <= pwdata[NF-1:0];
            if (apb_wr && a_level)  level_q  <= pwdata[NF-1:0];
            if (apb_wr && a_behave) behave_q <= pwdata[NF-1:0];
            flag_q      <= flag_d;
            cond_prev_q <= cond;
            irq         <= |(flag_d & enable_q); // R10
        end
    end
endmodule : hbiu_top
`default_nettype wire
